// ---- include/pmc_consts.svh ----
// constants for the programmable macrocell array: offsets, fields, resets, timing
// assumes a 32-bit AXI4-Lite register port and a 125 MHz ref_clk
// Functional notes
// - eight macrocells, each fed by eight product terms of the AND array.
// - three operating modes, chosen by stored configuration, never by a pin.
// - each macrocell is registered output, comb I/O, comb output or input.
// - after power-up reset every macrocell register is cleared low.
// - registered outputs invert the register, so they read high after reset.
// - each register can be preloaded high or low individually.
// - a 64-bit user signature stays readable even when secured.
// - once secured, array verify and preload are refused at once.
// - an undriven input or I/O pin is seen high by the array.
// - registered cells clock on the clock pin and enable on the low-true OE pin.
// - comb cells in registered mode use one term as enable, seven for the sum.
// - an input-configured cell drives no pin, except cells 0 and 7 in complex mode and cells 3 and 4 in simple mode.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_OFF_CTRL         12'h000
`define PMC_OFF_STATUS       12'h004
`define PMC_OFF_CFG          12'h008
`define PMC_OFF_PRELOAD      12'h00c
`define PMC_OFF_SIG_LO       12'h010
`define PMC_OFF_SIG_HI       12'h014
`define PMC_OFF_FUSE         12'h200
`define PMC_FUSE_MASK        12'he00

`define PMC_CTRL_SECURE      0
`define PMC_CTRL_MODE_LSB    1
`define PMC_PRELOAD_MASK_LSB 8
`define PMC_STAT_OUT_LSB     8
`define PMC_STAT_OE_LSB      16
`define PMC_STAT_SECURE      24
`define PMC_STAT_POR         25

`define PMC_CFG_RESET        16'hffff

`define PMC_RESP_OKAY        2'h0
`define PMC_RESP_SLVERR      2'h2
`define PMC_RESP_DECERR      2'h3

`define PMC_CLK_NS           8
`define PMC_POWER_UP_RESET_TIME_MAX_NS 1000
`define PMC_POWER_UP_RESET_TIME_TYP_NS 600
`define PMC_POR_CYCLES       (`PMC_POWER_UP_RESET_TIME_MAX_NS / `PMC_CLK_NS)

`endif

// ---- include/pmc_pkg.sv ----
// types for the programmable macrocell array
// assumes nothing beyond the constants header
package pmc_pkg;
	typedef enum logic [1:0] {MODE_REG, MODE_COMPLEX, MODE_SIMPLE} mode_t;
	typedef enum logic [1:0] {MC_REG, MC_COMB_IO, MC_COMB_OUT, MC_INPUT} mc_cfg_t;
	typedef enum logic [3:0] {
		SEL_CTRL, SEL_STATUS, SEL_CFG, SEL_PRELOAD,
		SEL_SIG_LO, SEL_SIG_HI, SEL_FUSE, SEL_NONE
	} reg_sel_t;
	typedef enum logic {POR_WAIT, POR_RUN} por_state_t;
endpackage

// ---- rtl/pmc_macrocell.sv ----
// one macrocell: product terms, sum term and output enable choice
// assumes array columns and fuse rows from the top; purely combinational
module pmc_macrocell #(
	parameter int COLS      = 40,
	parameter int PT_PER_MC = 8,
	parameter int IDX       = 0,
	parameter int NUM_MC    = 8
) (
	// array
	input  wire logic [COLS-1:0]           cols,
	input  wire logic [PT_PER_MC*COLS-1:0] rows,
	// configuration
	input  wire pmc_pkg::mode_t            mode,
	input  wire pmc_pkg::mc_cfg_t          cfg,
	input  wire logic                      oePinN,
	// result
	output logic                           sumTerm,
	output logic                           drvEn,
	output logic                           isReg
);
	logic [PT_PER_MC-1:0] pt;
	logic                 useOePt;
	logic                 isIn;
	logic                 outerMc;
	logic                 centerMc;

	for (genvar k = 0; k < PT_PER_MC; k++) begin : g_pt
		assign pt[k] = (|rows[k*COLS +: COLS]) & (&(cols | ~rows[k*COLS +: COLS]));
	end

	always_comb begin
		outerMc  = (IDX == 0) || (IDX == NUM_MC - 1);
		centerMc = (IDX == NUM_MC / 2 - 1) || (IDX == NUM_MC / 2);
		isReg    = (mode == pmc_pkg::MODE_REG) && (cfg == pmc_pkg::MC_REG);
		isIn     = (cfg == pmc_pkg::MC_INPUT)
			&& !((mode == pmc_pkg::MODE_COMPLEX) && outerMc)
			&& !((mode == pmc_pkg::MODE_SIMPLE) && centerMc);
		useOePt  = (mode != pmc_pkg::MODE_SIMPLE) && !isReg;
		sumTerm  = useOePt ? |pt[PT_PER_MC-1:1] : |pt;
		if (isIn) begin
			drvEn = 1'b0;
		end else if (isReg) begin
			drvEn = ~oePinN;
		end else if (useOePt) begin
			drvEn = pt[0];
		end else begin
			drvEn = 1'b1;
		end
	end
endmodule

// ---- rtl/pmc_sync.sv ----
// two-flop synchroniser for pin inputs
// assumes inputs asynchronous to ref_clk
module pmc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         srst,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule

// ---- rtl/programmable_macrocell_array.sv ----
// programmable sum-of-products array with eight macrocells and AXI4-Lite access
// assumes board pins asynchronous to ref_clk; srst models power-up
`include "pmc_consts.svh"
module programmable_macrocell_array #(
	parameter int NUM_IN    = 12,
	parameter int NUM_MC    = 8,
	parameter int PT_PER_MC = 8
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              srst,
	// axi4-lite write
	input  wire logic [11:0]       awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [11:0]       araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// device pins
	input  wire logic              clkPin,
	input  wire logic              oePinN,
	input  wire logic [NUM_IN-1:0] inPin,
	input  wire logic [NUM_IN-1:0] inDriven,
	input  wire logic [NUM_MC-1:0] ioIn,
	input  wire logic [NUM_MC-1:0] ioDriven,
	output logic      [NUM_MC-1:0] ioOut,
	output logic      [NUM_MC-1:0] ioOe
);
	localparam int COLS = 2 * (NUM_IN + NUM_MC);
	localparam int NPT  = NUM_MC * PT_PER_MC;
	localparam int HIW  = COLS - 32;

	function automatic pmc_pkg::reg_sel_t decodeAddr(input logic [11:0] a);
		if ((a & `PMC_FUSE_MASK) == `PMC_OFF_FUSE) return pmc_pkg::SEL_FUSE;
		case (a)
			`PMC_OFF_CTRL:    return pmc_pkg::SEL_CTRL;
			`PMC_OFF_STATUS:  return pmc_pkg::SEL_STATUS;
			`PMC_OFF_CFG:     return pmc_pkg::SEL_CFG;
			`PMC_OFF_PRELOAD: return pmc_pkg::SEL_PRELOAD;
			`PMC_OFF_SIG_LO:  return pmc_pkg::SEL_SIG_LO;
			`PMC_OFF_SIG_HI:  return pmc_pkg::SEL_SIG_HI;
			default:          return pmc_pkg::SEL_NONE;
		endcase
	endfunction

	function automatic logic [31:0] mergeStrb(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
		end
		return r;
	endfunction

	// pin synchronisers
	logic              clkS;
	logic              oeNS;
	logic [NUM_IN-1:0] inS;
	logic [NUM_IN-1:0] inDrvS;
	logic [NUM_MC-1:0] ioS;
	logic [NUM_MC-1:0] ioDrvS;

	pmc_sync #(.W(2 + 2 * NUM_IN + 2 * NUM_MC)) u_sync (
		.ref_clk (ref_clk),
		.srst    (srst),
		.din     ({clkPin, oePinN, inPin, inDriven, ioIn, ioDriven}),
		.dout    ({clkS, oeNS, inS, inDrvS, ioS, ioDrvS})
	);

	// fuse memory
	logic [COLS-1:0] fuseMem [NPT];
	logic            fuseWe;
	logic [5:0]      fuseIdx;
	logic [COLS-1:0] fuseRow;

	// register state
	logic                   awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [11:0]            awAddr_reg, awAddr_next;
	logic [31:0]            wData_reg, wData_next;
	logic [3:0]             wStrb_reg, wStrb_next;
	logic                   awready_next, wready_next, bvalid_next;
	logic [1:0]             bresp_next;
	logic                   arready_next, rvalid_next;
	logic [31:0]            rdata_next;
	logic [1:0]             rresp_next;
	logic                   secure_reg, secure_next;
	pmc_pkg::mode_t         mode_reg, mode_next;
	logic [15:0]            cfg_reg, cfg_next;
	logic [63:0]            sig_reg, sig_next;
	logic [NUM_MC-1:0]      q_reg, q_next;
	logic [7:0]             porCnt_reg, porCnt_next;
	pmc_pkg::por_state_t    por_reg, por_next;
	logic                   clkPrev_reg;
	logic [NUM_MC-1:0]      ioOut_next, ioOe_next;
	logic                   doWrite;
	pmc_pkg::reg_sel_t      wSel;
	pmc_pkg::reg_sel_t      rSel;
	logic [31:0]            wMerged;
	logic [31:0]            wMergedPl;

	// array evaluation
	logic [NUM_MC-1:0] sumT, drvEn, isReg, fbVal, ioVal;
	logic [NUM_IN-1:0] inVal;
	logic [COLS-1:0]   cols;

	always_comb begin
		inVal = inS | ~inDrvS;
		ioVal = (ioOe & ioOut) | (~ioOe & (ioS | ~ioDrvS));
		fbVal = (isReg & q_reg) | (~isReg & ioVal);
		for (int i = 0; i < NUM_IN + NUM_MC; i++) begin
			cols[2*i]   = (i < NUM_IN) ? inVal[i] : fbVal[i-NUM_IN];
			cols[2*i+1] = ~cols[2*i];
		end
	end

	for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
		logic [PT_PER_MC*COLS-1:0] rows;
		for (genvar k = 0; k < PT_PER_MC; k++) begin : g_row
			assign rows[k*COLS +: COLS] = fuseMem[m*PT_PER_MC+k];
		end
		pmc_macrocell #(
			.COLS      (COLS),
			.PT_PER_MC (PT_PER_MC),
			.IDX       (m),
			.NUM_MC    (NUM_MC)
		) u_mc (
			.cols    (cols),
			.rows    (rows),
			.mode    (mode_reg),
			.cfg     (pmc_pkg::mc_cfg_t'(cfg_reg[2*m +: 2])),
			.oePinN  (oeNS),
			.sumTerm (sumT[m]),
			.drvEn   (drvEn[m]),
			.isReg   (isReg[m])
		);
	end

	// bus handshakes and register writes
	always_comb begin
		awHeld_next  = awHeld_reg;
		awAddr_next  = awAddr_reg;
		wHeld_next   = wHeld_reg;
		wData_next   = wData_reg;
		wStrb_next   = wStrb_reg;
		bvalid_next  = bvalid;
		bresp_next   = bresp;
		secure_next  = secure_reg;
		mode_next    = mode_reg;
		cfg_next     = cfg_reg;
		sig_next     = sig_reg;
		fuseWe       = 1'b0;
		fuseIdx      = awAddr_reg[8:3];
		fuseRow      = fuseMem[awAddr_reg[8:3]];
		wSel         = decodeAddr(awAddr_reg);
		wMerged      = 32'h0;
		doWrite      = awHeld_reg && wHeld_reg && !bvalid;
		if (awvalid && awready) begin
			awHeld_next = 1'b1;
			awAddr_next = awaddr;
		end
		if (wvalid && wready) begin
			wHeld_next = 1'b1;
			wData_next = wdata;
			wStrb_next = wstrb;
		end
		if (bvalid && bready) begin
			bvalid_next = 1'b0;
		end
		if (doWrite) begin
			awHeld_next = 1'b0;
			wHeld_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = `PMC_RESP_OKAY;
			case (wSel)
				pmc_pkg::SEL_CTRL: begin
					wMerged = mergeStrb({29'h0, mode_reg, secure_reg}, wData_reg, wStrb_reg);
					secure_next = secure_reg | wMerged[`PMC_CTRL_SECURE];
					if (wMerged[`PMC_CTRL_MODE_LSB +: 2] != 2'h3) begin
						mode_next = pmc_pkg::mode_t'(wMerged[`PMC_CTRL_MODE_LSB +: 2]);
					end
				end
				pmc_pkg::SEL_CFG: begin
					wMerged  = mergeStrb({16'h0, cfg_reg}, wData_reg, wStrb_reg);
					cfg_next = wMerged[15:0];
				end
				pmc_pkg::SEL_PRELOAD: begin
					if (secure_reg) bresp_next = `PMC_RESP_SLVERR;
				end
				pmc_pkg::SEL_SIG_LO: sig_next[31:0] = mergeStrb(sig_reg[31:0], wData_reg,
					wStrb_reg);
				pmc_pkg::SEL_SIG_HI: sig_next[63:32] = mergeStrb(sig_reg[63:32], wData_reg,
					wStrb_reg);
				pmc_pkg::SEL_FUSE: begin
					fuseWe = (int'(fuseIdx) < NPT);
					if (awAddr_reg[2]) begin
						wMerged = mergeStrb({{(32-HIW){1'b0}}, fuseRow[COLS-1:32]}, wData_reg,
							wStrb_reg);
						fuseRow[COLS-1:32] = wMerged[HIW-1:0];
					end else begin
						fuseRow[31:0] = mergeStrb(fuseRow[31:0], wData_reg, wStrb_reg);
					end
					if (!fuseWe) bresp_next = `PMC_RESP_DECERR;
				end
				pmc_pkg::SEL_STATUS: ;
				default: bresp_next = `PMC_RESP_DECERR;
			endcase
		end
		awready_next = !awHeld_next && !bvalid_next;
		wready_next  = !wHeld_next && !bvalid_next;
	end

	// read decode
	always_comb begin
		arready_next = !rvalid;
		rvalid_next  = rvalid;
		rdata_next   = rdata;
		rresp_next   = rresp;
		rSel         = decodeAddr(araddr);
		if (rvalid && rready) begin
			rvalid_next  = 1'b0;
			arready_next = 1'b1;
		end
		if (arvalid && arready) begin
			arready_next = 1'b0;
			rvalid_next  = 1'b1;
			rresp_next   = `PMC_RESP_OKAY;
			rdata_next   = 32'h0;
			case (rSel)
				pmc_pkg::SEL_CTRL:   rdata_next = {29'h0, mode_reg, secure_reg};
				pmc_pkg::SEL_STATUS: begin
					rdata_next[NUM_MC-1:0]                         = q_reg;
					rdata_next[`PMC_STAT_OUT_LSB +: NUM_MC]        = ioOut;
					rdata_next[`PMC_STAT_OE_LSB +: NUM_MC]         = ioOe;
					rdata_next[`PMC_STAT_SECURE]                   = secure_reg;
					rdata_next[`PMC_STAT_POR]                      = por_reg == pmc_pkg::POR_WAIT;
				end
				pmc_pkg::SEL_CFG:    rdata_next = {16'h0, cfg_reg};
				pmc_pkg::SEL_SIG_LO: rdata_next = sig_reg[31:0];
				pmc_pkg::SEL_SIG_HI: rdata_next = sig_reg[63:32];
				pmc_pkg::SEL_FUSE: begin
					if (secure_reg) begin
						rresp_next = `PMC_RESP_SLVERR;
					end else if (int'(araddr[8:3]) >= NPT) begin
						rresp_next = `PMC_RESP_DECERR;
					end else if (araddr[2]) begin
						rdata_next[HIW-1:0] = fuseMem[araddr[8:3]][COLS-1:32];
					end else begin
						rdata_next = fuseMem[araddr[8:3]][31:0];
					end
				end
				pmc_pkg::SEL_PRELOAD: ;
				default: rresp_next = `PMC_RESP_DECERR;
			endcase
		end
	end

	// macrocell registers and pin drive
	always_comb begin
		por_next    = por_reg;
		wMergedPl   = 32'h0;
		porCnt_next = porCnt_reg;
		q_next      = q_reg;
		case (por_reg)
			pmc_pkg::POR_WAIT: begin
				porCnt_next = porCnt_reg + 8'h01;
				if (porCnt_reg == 8'(`PMC_POR_CYCLES - 1)) por_next = pmc_pkg::POR_RUN;
			end
			pmc_pkg::POR_RUN: begin
				if (clkS && !clkPrev_reg) q_next = (isReg & sumT) | (~isReg & q_reg);
			end
			default: por_next = pmc_pkg::POR_WAIT;
		endcase
		if (doWrite && (wSel == pmc_pkg::SEL_PRELOAD) && !secure_reg) begin
			wMergedPl = mergeStrb(32'h0, wData_reg, wStrb_reg);
			q_next = (q_next & ~wMergedPl[`PMC_PRELOAD_MASK_LSB +: NUM_MC])
				| (wMergedPl[NUM_MC-1:0] & wMergedPl[`PMC_PRELOAD_MASK_LSB +: NUM_MC]);
		end
		ioOut_next = (isReg & ~q_reg) | (~isReg & ~sumT);
		ioOe_next  = drvEn;
	end

	always_ff @(posedge ref_clk) begin
		if (fuseWe) fuseMem[fuseIdx] <= fuseRow;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			awHeld_reg  <= 1'b0;
			wHeld_reg   <= 1'b0;
			awAddr_reg  <= 12'h000;
			wData_reg   <= 32'h0;
			wStrb_reg   <= 4'h0;
			awready     <= 1'b0;
			wready      <= 1'b0;
			bvalid      <= 1'b0;
			bresp       <= `PMC_RESP_OKAY;
			arready     <= 1'b0;
			rvalid      <= 1'b0;
			rdata       <= 32'h0;
			rresp       <= `PMC_RESP_OKAY;
			secure_reg  <= 1'b0;
			mode_reg    <= pmc_pkg::MODE_REG;
			cfg_reg     <= `PMC_CFG_RESET;
			sig_reg     <= 64'h0;
			q_reg       <= '0;
			porCnt_reg  <= 8'h00;
			por_reg     <= pmc_pkg::POR_WAIT;
			clkPrev_reg <= 1'b0;
			ioOut       <= '1;
			ioOe        <= '0;
		end else begin
			awHeld_reg  <= awHeld_next;
			wHeld_reg   <= wHeld_next;
			awAddr_reg  <= awAddr_next;
			wData_reg   <= wData_next;
			wStrb_reg   <= wStrb_next;
			awready     <= awready_next;
			wready      <= wready_next;
			bvalid      <= bvalid_next;
			bresp       <= bresp_next;
			arready     <= arready_next;
			rvalid      <= rvalid_next;
			rdata       <= rdata_next;
			rresp       <= rresp_next;
			secure_reg  <= secure_next;
			mode_reg    <= mode_next;
			cfg_reg     <= cfg_next;
			sig_reg     <= sig_next;
			q_reg       <= q_next;
			porCnt_reg  <= porCnt_next;
			por_reg     <= por_next;
			clkPrev_reg <= clkS;
			ioOut       <= ioOut_next;
			ioOe        <= ioOe_next;
		end
	end
endmodule

// ---- sim/pmc_board_model.sv ----
// board logic around the array: clock pin pulses, pulled-up pins
// assumes bench requests pulses with clkGo and waits on clkBusy
module pmc_board_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// bench requests
	input  wire logic        clkGo,
	input  wire logic [11:0] inVal,
	input  wire logic [11:0] inDriven,
	input  wire logic [7:0]  ioVal,
	input  wire logic [7:0]  ioDriven,
	// device pins
	input  wire logic [7:0]  ioOut,
	input  wire logic [7:0]  ioOe,
	output logic             clkPin,
	output logic [11:0]      inPin,
	output logic [7:0]       ioIn,
	output logic             clkBusy
);
	timeunit 1ns;
	timeprecision 100ps;
	int phase;
	int porLeft;
	assign inPin = inVal | ~inDriven;
	assign ioIn = (ioOe & ioOut) | (~ioOe & ioDriven & ioVal) | (~ioOe & ~ioDriven);
	assign clkPin = (phase > 4) && (phase < 9);
	assign clkBusy = (phase != 0) || (porLeft != 0) || clkGo;
	always @(posedge ref_clk) begin
		if (srst) begin
			phase <= 0;
			porLeft <= 130;
		end else begin
			if (porLeft != 0)
				porLeft <= porLeft - 1;
			if (phase != 0)
				phase <= phase - 1;
			else if (clkGo && porLeft == 0)
				phase <= 12;
		end
	end
endmodule

// ---- sim/programmable_macrocell_array_asserts.sv ----
// assertions on register port and pin outputs of the macrocell array
// assumes one ref_clk domain, srst synchronous active high
module pmc_array_checker #(
	parameter int NUM_MC = 8
) (
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              srst,
	// register port
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	// pins
	input wire logic [NUM_MC-1:0] ioOut,
	input wire logic [NUM_MC-1:0] ioOe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk); endclocking
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_b_late;
		!bvalid ##1 bvalid;
	endsequence
	property p_rst_pins;
		srst |=> (ioOut == '1) && (ioOe == '0);
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins not idle in reset");
	property p_rst_bus;
		srst |=> !awready && !wready && !arready && !bvalid && !rvalid;
	endproperty
	a_rst_bus: assert property (p_rst_bus) else $error("bus not idle in reset");
	property p_ready_rise;
		$fell(srst) |=> awready && wready && arready;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready late");
	property p_wr_lat;
		disable iff (srst) s_wr_take |=> s_b_late;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer timing");
	property p_rd_lat;
		disable iff (srst) arvalid && arready |=> rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer timing");
	property p_b_hold;
		disable iff (srst) bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		disable iff (srst) rvalid && !rready |=> rvalid && $stable({rdata, rresp});
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_b_refuse;
		disable iff (srst) bvalid |-> !awready && !wready;
	endproperty
	a_b_refuse: assert property (p_b_refuse) else $error("write taken early");
	property p_r_refuse;
		disable iff (srst) rvalid |-> !arready;
	endproperty
	a_r_refuse: assert property (p_r_refuse) else $error("read taken early");
endmodule

bind programmable_macrocell_array pmc_array_checker #(.NUM_MC(NUM_MC)) chk (
	.ref_clk, .srst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ioOut, .ioOe
);

// ---- sim/tb_programmable_macrocell_array.sv ----
// self-checking bench: register port, power-up, preload, security, pins
// assumes checker bound to the design and the board model alongside
`include "pmc_consts.svh"
module tb_programmable_macrocell_array;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, clkPin, oePinN, clkGo, clkBusy;
	logic [11:0] awaddr, araddr, inPin, inDriven, inVal;
	logic [31:0] wdata, rdata, seed, sig;
	logic [7:0]  ioIn, ioDriven, ioOut, ioOe, ioVal, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [65:0] expR[$];
	logic [1:0]  expB[$];
	logic [65:0] e;
	int          miscompares, nChecks;

	programmable_macrocell_array dut (.ref_clk, .srst, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .clkPin, .oePinN, .inPin, .inDriven,
		.ioIn, .ioDriven, .ioOut, .ioOe);
	pmc_board_model board (.ref_clk, .srst, .clkGo, .inVal, .inDriven, .ioVal,
		.ioDriven, .ioOut, .ioOe, .clkPin, .inPin, .ioIn, .clkBusy);

	always #4 ref_clk = ~ref_clk;

	task automatic chk(input logic [33:0] g, x);
		nChecks++;
		if (g !== x) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	always @(posedge ref_clk) begin
		if (rvalid && rready && expR.size() > 0) begin
			e = expR.pop_front();
			chk({rresp, rdata & e[63:32]}, {e[65:64], e[31:0] & e[63:32]});
		end
		if (bvalid && bready && expB.size() > 0)
			chk({32'h0, bresp}, {32'h0, expB.pop_front()});
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw;
		logic w;
		expB.push_back(r);
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge ref_clk);
			if (awready)
				aw = 1'b0;
			if (wready)
				w = 1'b0;
			awvalid <= aw;
			wvalid <= w;
		end
		do @(posedge ref_clk); while (!bvalid);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, m, input logic [1:0] r);
		expR.push_back({r, m, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (!rvalid);
	endtask

	task automatic rs(input logic [31:0] d, m);
		rd(`PMC_OFF_STATUS, d, m, `PMC_RESP_OKAY);
	endtask

	task automatic pulse();
		clkGo <= 1'b1;
		@(posedge ref_clk);
		clkGo <= 1'b0;
		do @(posedge ref_clk); while (clkBusy);
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic give_verdict();
		if (expR.size() != 0 || expB.size() != 0)
			miscompares++;
		$display("checks %0d miscompares %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk);
		miscompares++;
		give_verdict();
	end

	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		seed = 32'h50b1212f;
		{awvalid, wvalid, bready, arvalid, rready, clkGo} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		wstrb = 4'hf;
		oePinN = 1'b1;
		{inVal, inDriven, ioVal, ioDriven} = '0;
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rs(32'h02000000, 32'h03ff00ff);
		rd(`PMC_OFF_CFG, 32'h0000ffff, 32'h0000ffff, `PMC_RESP_OKAY);
		sig = $random(seed);
		wr(`PMC_OFF_SIG_LO, sig, `PMC_RESP_OKAY);
		wr(`PMC_OFF_SIG_HI, ~sig, `PMC_RESP_OKAY);
		rd(`PMC_OFF_SIG_HI, ~sig, 32'hffffffff, `PMC_RESP_OKAY);
		repeat (130) @(posedge ref_clk);
		rs(32'h0, 32'h03000000);
		wr(`PMC_OFF_CFG, 32'h0000fffc, `PMC_RESP_OKAY);
		wr(`PMC_OFF_CTRL, 32'h0, `PMC_RESP_OKAY);
		for (int t = 0; t < 64; t++) begin
			wr(`PMC_OFF_FUSE + 12'(8 * t), {31'h0, t == 0}, `PMC_RESP_OKAY);
			wr(`PMC_OFF_FUSE + 12'(8 * t + 4), 32'h0, `PMC_RESP_OKAY);
		end
		inDriven <= 12'h001;
		pulse();
		rs(32'h00000100, 32'h00ff01ff);
		inDriven <= 12'h000;
		pulse();
		rs(32'h00000001, 32'h00ff01ff);
		oePinN <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rs(32'h00010001, 32'h00ff01ff);
		repeat (4) begin
			v = 8'($random(seed));
			wr(`PMC_OFF_PRELOAD, {16'h0, 8'hff, v}, `PMC_RESP_OKAY);
			rs({8'h0, 8'h01, 7'h0, ~v[0], v}, 32'h00ff01ff);
			wr(`PMC_OFF_PRELOAD, 32'h00000200, `PMC_RESP_OKAY);
			rs({16'h0001, 7'h0, ~v[0], v & 8'hfd}, 32'h00ff01ff);
		end
		wr(`PMC_OFF_CTRL, 32'h1, `PMC_RESP_OKAY);
		wr(`PMC_OFF_PRELOAD, 32'h0000ff00, `PMC_RESP_SLVERR);
		rs({7'h0, 1'b1, 8'h01, 7'h0, ~v[0], v & 8'hfd}, 32'h01ff01ff);
		rd(`PMC_OFF_FUSE, 32'h0, 32'h0, `PMC_RESP_SLVERR);
		rd(`PMC_OFF_SIG_LO, sig, 32'hffffffff, `PMC_RESP_OKAY);
		rd(12'h018, 32'h0, 32'h0, `PMC_RESP_DECERR);
		wr(`PMC_OFF_CTRL, 32'h2, `PMC_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		rs({7'h0, 1'b1, 8'h01, 8'h01, v & 8'hfd}, 32'h01ff01ff);
		wr(`PMC_OFF_CTRL, 32'h4, `PMC_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		rs({7'h0, 1'b1, 8'h19, 8'h18, v & 8'hfd}, 32'h01ff19ff);
		@(posedge ref_clk);
		give_verdict();
	end
endmodule
